// ===== inc/rx_pkg.sv
package rx_pkg;
	// APB byte offsets
	localparam logic [11:0] ctrl_one_off   = 12'h000;
	localparam logic [11:0] ctrl_two_off   = 12'h004;
	localparam logic [11:0] status_one_off = 12'h008;
	localparam logic [11:0] data_off       = 12'h00c;
	localparam logic [11:0] baud_off       = 12'h010;
	localparam logic [11:0] status_two_off = 12'h014;
	// control_reg_one fields
	localparam int          len9_bit       = 4;
	// control_reg_two fields
	localparam int          irq_en_bit     = 5;
	localparam int          rx_en_bit      = 2;
	localparam int          ninth_bit_pos  = 7;
	// status_reg_one fields
	localparam int          full_bit       = 5;
	localparam int          over_bit       = 3;
	localparam int          noise_bit      = 2;
	localparam int          frame_bit      = 1;
	// status_reg_two fields
	localparam int          brk_bit        = 1;
	// Reset values
	localparam logic [7:0]  ctrl_one_rst   = 8'h00;
	localparam logic [7:0]  ctrl_two_rst   = 8'h00;
	localparam logic [15:0] baud_div_rst   = 16'h0001;
	// Oversampling
	localparam logic [4:0]  ticks_per_bit  = 5'h10;
	localparam logic [4:0]  tick_s3        = 5'h03;
	localparam logic [4:0]  tick_s5        = 5'h05;
	localparam logic [4:0]  tick_s7        = 5'h07;
	localparam logic [4:0]  tick_s8        = 5'h08;
	localparam logic [4:0]  tick_s9        = 5'h09;
	localparam logic [4:0]  tick_s10       = 5'h0a;
	localparam logic [3:0]  bits_8        = 4'h8;
	localparam logic [3:0]  bits_9        = 4'h9;
endpackage : rx_pkg

// ===== inc/tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
	logic        tick;
	logic [15:0] divisor;
	modport gen (output tick, input divisor);
	modport use_side (input tick, output divisor);
endinterface : tick_if
`default_nettype wire

// ===== rtl/tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tick_gen
	import rx_pkg::*;
(
	input  wire logic clock_in,
	input  wire logic reset_in,
	tick_if.gen       t
);
	logic [15:0] cnt_r;

	// One tick every divisor clocks, at 16x baud
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			cnt_r  <= 16'h0000;
			t.tick <= 1'b0;
		end else if (cnt_r + 16'h0001 >= t.divisor) begin
			cnt_r  <= 16'h0000;
			t.tick <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 16'h0001;
			t.tick <= 1'b0;
		end
	end
endmodule : tick_gen
`default_nettype wire

// ===== rtl/serial_receiver.sv
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R01] 8 or 9 bit length by control bit
// [R02] Ninth field: bit 8, or copy of bit 7
// [R03] Shift in, move data to read-only register
// [R04] Transfer sets full flag; enable gates irq
// [R05] Sample at sixteen times the baud rate
// [R06] Realign after start and 1-to-0 data change
// [R07] Search low after three highs, then count
// [R08] Start accepted on 000/001/010/100, noise flagged
// [R09] Failed start resets counter, restarts search
// [R10] Data bit majority of ticks 8-10, noise
// [R11] High start samples 8-10 flag noise only
// [R12] Stop majority; zero frames error, disagreement noise
// [R13] Framing error set with full flag
// [R14] Break character sets framing error
// [R15] Realign on valid falling edge within character
// [R16] Break sets break, full; clears data, ninth
// [R17] Overrun keeps old character, sets flag
// [R18] Ticks 1-16 per bit, wrap until stop
module serial_receiver
	import rx_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        reset_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        rx_line_in,
	output logic             rx_irq_out
);
	typedef enum logic [1:0] {idle_s, start_s, data_s, stop_s} rx_state_e;

	tick_if tk ();
	tick_gen u_tick (.clock_in(clock_in), .reset_in(reset_in), .t(tk));

	logic [7:0]  control_reg_one_r;
	logic [7:0]  control_reg_two_r;
	logic [15:0] baud_div_r;
	logic [7:0]  serial_data_reg_r;
	logic        rx_ninth_bit_r;
	logic        rx_full_flag_r, overrun_r, noise_flag_r, framing_error_flag_r, break_flag_r;
	logic        sync1_r, sync2_r;
	logic [2:0]  hist_r;
	rx_state_e   state_r;
	logic [4:0]  oversample_tick_r;
	logic [3:0]  bit_cnt_r;
	logic [8:0]  shift_r;
	logic [2:0]  samp_r;
	logic        prev_bit_r, char_noise_r;
	logic        done_r, done_fe_r, done_nf_r, done_brk_r;
	logic [8:0]  done_data_r;

	assign tk.divisor = baud_div_r;

	////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states
	logic acc, wr, rd, rd_status;
	assign acc        = psel_in && penable_in;
	assign wr         = acc && pwrite_in;
	assign rd         = acc && !pwrite_in;
	assign pready_out = 1'b1;
	assign rd_status  = rd && paddr_in == status_one_off;
	logic sts_seen_r;
	logic data_read;
	// Full flag clears by status read then data read
	assign data_read = rd && paddr_in == data_off && sts_seen_r;

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			control_reg_one_r <= ctrl_one_rst;
			control_reg_two_r <= ctrl_two_rst;
			baud_div_r        <= baud_div_rst;
		end else if (wr) begin
			if (paddr_in == ctrl_one_off)
				control_reg_one_r <= pwdata_in[7:0];
			if (paddr_in == ctrl_two_off)
				control_reg_two_r <= {1'b0, pwdata_in[6:0]};
			if (paddr_in == baud_off)
				baud_div_r <= (pwdata_in[15:0] == 16'h0000) ? baud_div_rst : pwdata_in[15:0];
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in)
			sts_seen_r <= 1'b0;
		else if (rd_status)
			sts_seen_r <= 1'b1;
		else if (data_read)
			sts_seen_r <= 1'b0;
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			prdata_out  <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else begin
			prdata_out  <= 32'h0000_0000;
			pslverr_out <= 1'b0;
			if (psel_in && !penable_in && !pwrite_in) begin
				unique case (paddr_in)
					ctrl_one_off:   prdata_out[7:0] <= control_reg_one_r;
					ctrl_two_off: begin
						prdata_out[7:0] <= control_reg_two_r;
						prdata_out[ninth_bit_pos] <= rx_ninth_bit_r; // [R02]
					end
					status_one_off: begin
						prdata_out[full_bit]  <= rx_full_flag_r;
						prdata_out[over_bit]  <= overrun_r;
						prdata_out[noise_bit] <= noise_flag_r;
						prdata_out[frame_bit] <= framing_error_flag_r;
					end
					data_off:       prdata_out[7:0] <= serial_data_reg_r; // [R03]
					baud_off:       prdata_out[15:0] <= baud_div_r;
					status_two_off: prdata_out[brk_bit] <= break_flag_r;
					default:        prdata_out <= 32'h0000_0000;
				endcase
			end
			if (psel_in && !penable_in && !(paddr_in inside {ctrl_one_off, ctrl_two_off,
				status_one_off, data_off, baud_off, status_two_off}))
				pslverr_out <= 1'b1;
		end
	end
	// Read data registered in setup, valid during access phase

	////////////////////////////////////////////////////////////////////////
	// Line synchroniser and sample history
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= rx_line_in;
			sync2_r <= sync1_r;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in)
			hist_r <= 3'b111;
		else if (tk.tick)
			hist_r <= {hist_r[1:0], sync2_r}; // [R05]
	end

	////////////////////////////////////////////////////////////////////////
	// Data recovery
	logic       rx_en, len9;
	logic [2:0] s3;
	logic       maj, disagree, start_ok, start_nf;
	logic [3:0] nbits;
	assign rx_en    = control_reg_two_r[rx_en_bit];
	assign len9     = control_reg_one_r[len9_bit]; // [R01]
	assign nbits    = len9 ? bits_9 : bits_8;
	assign s3       = {samp_r[2:1], sync2_r};
	assign maj      = (s3[2] & s3[1]) | (s3[2] & s3[0]) | (s3[1] & s3[0]); // [R10]
	assign disagree = !(s3 == 3'b000 || s3 == 3'b111);
	assign start_ok = s3 inside {3'b000, 3'b001, 3'b010, 3'b100}; // [R08]
	assign start_nf = s3 != 3'b000;

	always_ff @(posedge clock_in) begin
		done_r <= 1'b0;
		if (reset_in || !rx_en) begin
			state_r           <= idle_s;
			oversample_tick_r <= 5'h00;
			bit_cnt_r         <= 4'h0;
			shift_r           <= 9'h000;
			samp_r            <= 3'b000;
			prev_bit_r        <= 1'b1;
			char_noise_r      <= 1'b0;
			done_fe_r         <= 1'b0;
			done_nf_r         <= 1'b0;
			done_brk_r        <= 1'b0;
			done_data_r       <= 9'h000;
		end else if (tk.tick) begin
			if (oversample_tick_r == ticks_per_bit)
				oversample_tick_r <= 5'h01; // [R18]
			else
				oversample_tick_r <= oversample_tick_r + 5'h01;
			if (oversample_tick_r == tick_s3 || oversample_tick_r == tick_s8)
				samp_r[2] <= sync2_r;
			if (oversample_tick_r == tick_s5 || oversample_tick_r == tick_s9)
				samp_r[1] <= sync2_r;
			unique case (state_r)
				idle_s: begin
					if (hist_r == 3'b111 && !sync2_r) begin // [R07]
						state_r           <= start_s;
						oversample_tick_r <= 5'h02; // [R06]
						char_noise_r      <= 1'b0;
						// Stale bits would spoil the all-zero break test in 8-bit mode
						shift_r           <= 9'h000;
					end
				end
				start_s: begin
					if (oversample_tick_r == tick_s7) begin
						if (!start_ok) begin
							state_r           <= idle_s; // [R09]
							oversample_tick_r <= 5'h00;
						end else
							char_noise_r <= start_nf;
					end
					if (oversample_tick_r == tick_s10) begin
						if (disagree || maj)
							char_noise_r <= 1'b1; // [R11]
						prev_bit_r <= 1'b0;
					end
					if (oversample_tick_r == ticks_per_bit) begin
						state_r   <= data_s;
						bit_cnt_r <= 4'h0;
					end
				end
				data_s, stop_s: begin
					// Falling edge after a voted 1 realigns the phase
					if (prev_bit_r && hist_r[0] && !sync2_r &&
						oversample_tick_r > tick_s10) begin
						oversample_tick_r <= 5'h02; // [R06] [R15]
						prev_bit_r        <= 1'b0;
					end
					if (oversample_tick_r == tick_s10) begin
						if (disagree)
							char_noise_r <= 1'b1; // [R10] [R12]
						prev_bit_r <= maj;
						if (state_r == data_s) begin
							shift_r   <= {maj, shift_r[8:1]};
							bit_cnt_r <= bit_cnt_r + 4'h1;
							if (bit_cnt_r + 4'h1 == nbits)
								state_r <= stop_s;
						end else begin
							state_r           <= idle_s;
							oversample_tick_r <= 5'h00;
							done_r            <= 1'b1;
							done_fe_r         <= !maj; // [R12] [R14]
							done_nf_r         <= char_noise_r || disagree;
							done_brk_r        <= !maj && shift_r == 9'h000; // [R16]
							done_data_r       <= len9 ? shift_r : {shift_r[8], shift_r[8:1]}; // [R02]
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags; set wins over clear
	logic accept;
	assign accept = done_r && !rx_full_flag_r; // [R17]

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			serial_data_reg_r <= 8'h00;
			rx_ninth_bit_r    <= 1'b0;
		end else if (accept) begin
			serial_data_reg_r <= done_brk_r ? 8'h00 : done_data_r[7:0]; // [R03] [R16]
			rx_ninth_bit_r    <= done_brk_r ? 1'b0 : done_data_r[8]; // [R02]
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			rx_full_flag_r       <= 1'b0;
			framing_error_flag_r <= 1'b0;
			noise_flag_r         <= 1'b0;
			break_flag_r         <= 1'b0;
		end else if (accept) begin
			rx_full_flag_r       <= 1'b1; // [R04]
			framing_error_flag_r <= done_fe_r; // [R13]
			noise_flag_r         <= done_nf_r;
			break_flag_r         <= done_brk_r; // [R16]
		end else if (data_read) begin
			rx_full_flag_r       <= 1'b0;
			framing_error_flag_r <= 1'b0;
			noise_flag_r         <= 1'b0;
			break_flag_r         <= 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in)
			overrun_r <= 1'b0;
		else if (done_r && rx_full_flag_r)
			overrun_r <= 1'b1; // [R17] Set wins over a same-cycle clear
		else if (data_read)
			overrun_r <= 1'b0;
	end

	assign rx_irq_out = rx_full_flag_r && control_reg_two_r[irq_en_bit]; // [R04]

	////////////////////////////////////////////////////////////////////////
	// Checks
	// Candidate start: quiet line, then a low sample on a tick
	sequence s_start_edge;
		tk.tick && state_r == idle_s && hist_r == 3'b111 && !sync2_r;
	endsequence : s_start_edge
	sequence s_start_armed;
		state_r == start_s && oversample_tick_r == 5'h02;
	endsequence : s_start_armed

	a_full_on_accept: assert property (@(posedge clock_in) disable iff (reset_in) // [R04]
		accept |=> rx_full_flag_r) else $error("full flag not set");
	a_fe_with_full: assert property (@(posedge clock_in) disable iff (reset_in) // [R13]
		$rose(framing_error_flag_r) |-> $rose(rx_full_flag_r)) else $error("fe late");
	a_overrun_keeps: assert property (@(posedge clock_in) disable iff (reset_in) // [R17]
		done_r && rx_full_flag_r |=> overrun_r && $stable(serial_data_reg_r))
		else $error("overrun lost data");
	a_irq_gate: assert property (@(posedge clock_in) disable iff (reset_in) // [R04]
		accept && control_reg_two_r[irq_en_bit] && !wr |=> rx_irq_out)
		else $error("irq missing");
	a_tick_range: assert property (@(posedge clock_in) disable iff (reset_in) // [R18]
		oversample_tick_r <= ticks_per_bit) else $error("tick out of range");
	a_bad_start: assert property (@(posedge clock_in) disable iff (reset_in || !rx_en) // [R09]
		tk.tick && state_r == start_s && oversample_tick_r == tick_s7 && !start_ok
		|=> state_r == idle_s) else $error("bad start kept");
	a_break_clear: assert property (@(posedge clock_in) disable iff (reset_in) // [R16]
		accept && done_brk_r |=> serial_data_reg_r == 8'h00 && break_flag_r
		&& framing_error_flag_r) else $error("break effects");
	a_start_seek: assert property (@(posedge clock_in) disable iff (reset_in || !rx_en) // [R07]
		s_start_edge |=> s_start_armed)
		else $error("start search");
endmodule : serial_receiver
`default_nettype wire

// ===== verification/serial_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model #(
	parameter int bit_clks = 32
) (
	input  wire logic clock_in,
	output logic      line_out
);
	initial line_out = 1'b1;

	// Start, data LSB first, stop; glitch flips one tick sample mid-bit
	task automatic send(input logic [8:0] data, input int nbits, input logic stop,
		input int glitch);
		logic b;
		for (int i = 0; i < nbits + 2; i++) begin
			b = (i == 0) ? 1'b0 : (i == nbits + 1) ? stop : data[i-1];
			for (int c = 0; c < bit_clks; c++) begin
				@(posedge clock_in);
				line_out <= (i == glitch && c >= 17 && c < 19) ? ~b : b;
			end
		end
		// Idle line is high between frames
		@(posedge clock_in);
		line_out <= 1'b1;
		repeat (2 * bit_clks) @(posedge clock_in);
	endtask : send

	task automatic pulse(input int n);
		@(posedge clock_in);
		line_out <= 1'b0;
		repeat (n) @(posedge clock_in);
		line_out <= 1'b1;
	endtask : pulse
endmodule : serial_tx_model
`default_nettype wire

// ===== verification/serial_receiver_data_recovery_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_receiver_data_recovery_tb;
	import rx_pkg::*;
	logic        clock_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [11:0] paddr    = 12'h000;
	logic [31:0] pwdata   = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_line;
	logic        rx_irq;
	logic [31:0] rdata;
	logic        rerr;
	int          n_errors    = 0;
	int          check_count = 0;
	int          cycles      = 0;

	always #10 clock_in = ~clock_in;

	serial_receiver u_dut (
		.clock_in    (clock_in),
		.reset_in    (reset_in),
		.psel_in     (psel),
		.penable_in  (penable),
		.pwrite_in   (pwrite),
		.paddr_in    (paddr),
		.pwdata_in   (pwdata),
		.prdata_out  (prdata),
		.pready_out  (pready),
		.pslverr_out (pslverr),
		.rx_line_in  (rx_line),
		.rx_irq_out  (rx_irq)
	);

	// Divisor 2 gives 32 clocks per bit
	serial_tx_model #(.bit_clks(32)) u_tx (
		.clock_in (clock_in),
		.line_out (rx_line)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors++;
			end_sim();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clock_in);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clock_in);
		penable <= 1'b1;
		do @(posedge clock_in); while (pready !== 1'b1);
		rdata = prdata;
		rerr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rdata, exp);
	endtask : rd

	task automatic wait_irq();
		for (int i = 0; i < 2000 && rx_irq !== 1'b1; i++)
			@(posedge clock_in);
		check({31'h0, rx_irq}, 32'h1);
	endtask : wait_irq

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clock_in);
		reset_in <= 1'b0;
		rd(ctrl_one_off, 32'h0);
		rd(baud_off, 32'h1);
		rd(ctrl_two_off, 32'h0);
		apb(1'b0, 12'h018, 32'h0);
		check({31'h0, rerr}, 32'h1);
		check(rdata, 32'h0);
		apb(1'b1, baud_off, 32'h2);
		apb(1'b1, ctrl_two_off, 32'h24);
		$display("test registers done");

		u_tx.send(9'h0a5, 8, 1'b1, -1);
		wait_irq();
		rd(status_one_off, 32'h20);
		rd(ctrl_two_off, 32'ha4);
		apb(1'b1, ctrl_two_off, 32'h04);
		// Irq disable lands at the access edge; look one edge later
		@(posedge clock_in);
		check({31'h0, rx_irq}, 32'h0);
		apb(1'b1, ctrl_two_off, 32'h24);
		rd(data_off, 32'ha5);
		@(posedge clock_in);
		check({31'h0, rx_irq}, 32'h0);
		$display("test 8-bit done");

		apb(1'b1, ctrl_one_off, 32'h10);
		u_tx.send(9'h0bc, 9, 1'b1, -1);
		wait_irq();
		rd(ctrl_two_off, 32'h24);
		rd(status_one_off, 32'h20);
		rd(data_off, 32'hbc);
		apb(1'b1, ctrl_one_off, 32'h0);
		$display("test 9-bit done");

		u_tx.send(9'h00f, 8, 1'b1, 2);
		wait_irq();
		rd(status_one_off, 32'h24);
		rd(data_off, 32'h0f);
		$display("test noise done");

		// One high sample late in the start bit
		u_tx.send(9'h0c3, 8, 1'b1, 0);
		wait_irq();
		rd(status_one_off, 32'h24);
		rd(data_off, 32'hc3);
		$display("test start noise done");

		u_tx.send(9'h055, 8, 1'b0, -1);
		wait_irq();
		rd(status_one_off, 32'h22);
		rd(data_off, 32'h55);
		$display("test framing done");

		u_tx.send(9'h000, 8, 1'b0, -1);
		wait_irq();
		rd(status_two_off, 32'h2);
		rd(status_one_off, 32'h22);
		rd(data_off, 32'h0);
		rd(ctrl_two_off, 32'h24);
		$display("test break done");

		u_tx.send(9'h011, 8, 1'b1, -1);
		wait_irq();
		u_tx.send(9'h022, 8, 1'b1, -1);
		rd(status_one_off, 32'h28);
		rd(data_off, 32'h11);
		$display("test overrun done");

		// Too short to pass the three verification samples
		u_tx.pulse(4);
		repeat (400) @(posedge clock_in);
		rd(status_one_off, 32'h0);
		u_tx.send(9'h03c, 8, 1'b1, -1);
		wait_irq();
		rd(status_one_off, 32'h20);
		rd(data_off, 32'h3c);
		$display("test false start done");
		end_sim();
	end
endmodule : serial_receiver_data_recovery_tb
`default_nettype wire
